// *** shared/msix_ctrl_defines.svh ***
// constants of the vector message control block
`ifndef MSIX_CTRL_DEFINES_SVH
`define MSIX_CTRL_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL      8'h00
`define OFS_VMASK     8'h04
`define OFS_PEND      8'h08
`define OFS_STAT      8'h0C

// ----------------------------------------
// control register fields
// ----------------------------------------
`define BIT_EN        15
`define BIT_FMASK     14
`define RSV_HI        13
`define RSV_LO        11
`define SIZE_HI       10
`define SIZE_W        11
`define CTRL_LANE     1
`define EN_RST        1'b0
`define FMASK_RST     1'b0

// ----------------------------------------
// bus answers and misc
// ----------------------------------------
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define WORD_LSB      2
`define NUM_VEC_DEF   4

`endif

// *** shared/msix_pkg.sv ***
// types of the vector message control block
`default_nettype none
package msix_pkg;

	// ----------------------------------------
	// writable control bits
	// ----------------------------------------
	typedef struct packed {
		logic en;     // extended_msg_irq_on
		logic fmask;  // function-wide mask
	} ctrl_t;

	// ----------------------------------------
	// service request mode
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_INTX,
		MODE_MSIX,
		MODE_MSI
	} irq_mode_t;

	// ----------------------------------------
	// register select
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEL_CTRL,
		SEL_VMASK,
		SEL_PEND,
		SEL_STAT,
		SEL_NONE
	} sel_t;

endpackage
`default_nettype wire

// *** core/vector_gate.sv ***
// per-vector masking, pending and message fire decisions
`timescale 1ns/100ps
`default_nettype none
`include "msix_ctrl_defines.svh"

module vector_gate #(
	parameter int NUM_VEC = `NUM_VEC_DEF
) (
	// control
	input  wire logic [1:0]         ctrl_bits, // {en, fmask}
	input  wire logic               plain_on,
	input  wire logic [NUM_VEC-1:0] vmask,
	// vector state
	input  wire logic [NUM_VEC-1:0] pend,
	input  wire logic [NUM_VEC-1:0] req,
	input  wire logic [NUM_VEC-1:0] clr,
	// next state
	output logic      [NUM_VEC-1:0] pend_nxt,
	output logic      [NUM_VEC-1:0] fire_nxt
);
	import msix_pkg::*;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	ctrl_t ctrl;             // unpacked control view
	wire   msix_ok;          // messages allowed
	assign ctrl    = ctrl_t'(ctrl_bits);
	assign msix_ok = ctrl.en & ~plain_on;

	// ----------------------------------------
	// one slice per vector
	// ----------------------------------------
	for (genvar i = 0; i < NUM_VEC; i++) begin : g_vec
		wire eff_mask;   // masked by function or vector
		wire want;       // request outstanding
		// function mask overrides, else own mask decides
		assign eff_mask    = ctrl.fmask | vmask[i];
		assign want        = pend[i] | req[i];
		assign fire_nxt[i] = msix_ok & ~eff_mask & want;
		// a new request beats a software clear
		assign pend_nxt[i] = want & ~fire_nxt[i] & ~(clr[i] & ~req[i]);
	end

endmodule // vector_gate
`default_nettype wire

// *** core/msix_message_control.sv ***
// vector message control register with axi4-lite access
//
// Function
// - enable bit 15 resets to zero
// - both enables clear: request via legacy pin
// - enable set, plain clear: messages, no pin
// - enable clear: never issue a message
// - function mask set masks every vector
// - function mask clear: vector mask decides
// - function mask writes keep vector masks
// - function mask resets zero, read/write
// - bits 13 to 11 read zero
// - size field reads entries minus one
`timescale 1ns/100ps
`default_nettype none
`include "msix_ctrl_defines.svh"

module msix_message_control #(
	parameter int NUM_VEC       = `NUM_VEC_DEF, // table entries
	parameter bit INTX_SUPPORTED = 1'b1          // legacy pin present
) (
	// clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// write address channel
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	// write data channel
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	// write response channel
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// read address channel
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	// read data channel
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// function side
	input  wire logic [NUM_VEC-1:0] vec_req,
	input  wire logic               plain_msg_irq_on,
	output logic [NUM_VEC-1:0]      msg_fire,
	output logic                    intx_n,
	output logic                    extended_msg_irq_on
);
	import msix_pkg::*;

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	// map a byte address onto a register
	function automatic sel_t reg_sel(input logic [7:0] a);
		logic [7:0] w;
		w = {a[7:`WORD_LSB], 2'h0};
		case (w)
			`OFS_CTRL:  reg_sel = SEL_CTRL;
			`OFS_VMASK: reg_sel = SEL_VMASK;
			`OFS_PEND:  reg_sel = SEL_PEND;
			`OFS_STAT:  reg_sel = SEL_STAT;
			default:    reg_sel = SEL_NONE;
		endcase
	endfunction

	// expand byte strobes to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam logic [`SIZE_W-1:0] SIZE_CODE = `SIZE_W'(NUM_VEC - 1);

	ctrl_t              ctrl_r;     // enable and function mask
	logic [NUM_VEC-1:0] vmask_r;    // per-vector masks
	logic [NUM_VEC-1:0] pend_r;     // pending requests
	logic [NUM_VEC-1:0] fire_r;     // message pulse per vector
	logic               intx_n_r;   // legacy pin, active low
	logic               awready_r;  // address slot free
	logic               wready_r;   // data slot free
	logic               aw_held_r;  // address captured
	logic               w_held_r;   // data captured
	logic [7:0]         waddr_r;    // captured address
	logic [31:0]        wdata_r;    // captured data
	logic [3:0]         wstrb_r;    // captured strobes
	logic               bvalid_r;   // write answer
	logic [1:0]         bresp_r;    // write status
	logic               arready_r;  // read slot free
	logic               rvalid_r;   // read answer
	logic [31:0]        rdata_r;    // read word
	logic [1:0]         rresp_r;    // read status
	logic               rd_ctrl_r;  // last read hit control

	// ----------------------------------------
	// combinational decode
	// ----------------------------------------
	wire               aw_take;    // address handshake
	wire               w_take;     // data handshake
	wire               ar_take;    // read handshake
	wire               do_write;   // both halves present
	wire sel_t         wsel;       // write target
	wire sel_t         rsel;       // read target
	wire [31:0]        wbits;      // written bit lanes
	wire               ctrl_wr;    // control byte written
	wire [NUM_VEC-1:0] clr_vec;    // pending clear mask
	wire [NUM_VEC-1:0] vmask_nxt;  // updated vector masks
	wire [NUM_VEC-1:0] pend_nxt;   // from vector gate
	wire [NUM_VEC-1:0] fire_nxt;   // from vector gate
	wire               legacy_on;  // legacy pin mode
	wire irq_mode_t    mode;       // current request mode
	wire [31:0]        ctrl_word;  // control read image
	wire [31:0]        rd_word;    // read mux result

	assign aw_take  = s_axi_awvalid & awready_r;
	assign w_take   = s_axi_wvalid & wready_r;
	assign ar_take  = s_axi_arvalid & arready_r;
	assign do_write = aw_held_r & w_held_r & ~bvalid_r;
	assign wsel     = reg_sel(waddr_r);
	assign rsel     = reg_sel(s_axi_araddr);
	assign wbits    = lane_mask(wstrb_r);
	assign ctrl_wr  = do_write & (wsel == SEL_CTRL) & wstrb_r[`CTRL_LANE];

	// vector masks only change through their own register
	assign vmask_nxt = (do_write && wsel == SEL_VMASK)
		? ((vmask_r & ~wbits[NUM_VEC-1:0]) | (wdata_r[NUM_VEC-1:0] & wbits[NUM_VEC-1:0]))
		: vmask_r;

	// write one clears a pending bit
	assign clr_vec = (do_write && wsel == SEL_PEND)
		? (wdata_r[NUM_VEC-1:0] & wbits[NUM_VEC-1:0]) : '0;

	// legacy pin serves only when both enables are clear
	assign legacy_on = INTX_SUPPORTED & ~ctrl_r.en & ~plain_msg_irq_on;

	assign mode = plain_msg_irq_on ? MODE_MSI
		: ctrl_r.en ? MODE_MSIX
		: legacy_on ? MODE_INTX : MODE_OFF;

	// reserved bits read zero, size reads entries minus one
	assign ctrl_word = {16'h0000, ctrl_r.en, ctrl_r.fmask, 3'h0, SIZE_CODE};

	assign rd_word = (rsel == SEL_CTRL)  ? ctrl_word
		: (rsel == SEL_VMASK) ? 32'(vmask_r)
		: (rsel == SEL_PEND)  ? 32'(pend_r)
		: (rsel == SEL_STAT)  ? {30'h0, mode} : 32'h0000_0000;

	// ----------------------------------------
	// vector gating
	// ----------------------------------------
	vector_gate #(
		.NUM_VEC  (NUM_VEC)
	) u_gate (
		.ctrl_bits(ctrl_r),
		.plain_on (plain_msg_irq_on),
		.vmask    (vmask_r),
		.pend     (pend_r),
		.req      (vec_req),
		.clr      (clr_vec),
		.pend_nxt (pend_nxt),
		.fire_nxt (fire_nxt)
	);

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// only the enable and function mask store; other bits drop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r.en    <= `EN_RST;
			ctrl_r.fmask <= `FMASK_RST;
		end else if (ctrl_wr) begin
			ctrl_r.en    <= wdata_r[`BIT_EN];
			ctrl_r.fmask <= wdata_r[`BIT_FMASK];
		end
	end

	// ----------------------------------------
	// vector state and outputs
	// ----------------------------------------
	// masks, pending, message pulses and legacy pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vmask_r  <= '0;
			pend_r   <= '0;
			fire_r   <= '0;
			intx_n_r <= 1'b1;
		end else begin
			vmask_r  <= vmask_nxt;
			pend_r   <= pend_nxt;
			fire_r   <= fire_nxt;
			intx_n_r <= ~(legacy_on & (|pend_r));
		end
	end

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	// capture address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			waddr_r   <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			if (aw_take) begin
				awready_r <= 1'b0;
				aw_held_r <= 1'b1;
				waddr_r   <= s_axi_awaddr;
			end else if (do_write) begin
				awready_r <= 1'b1;
				aw_held_r <= 1'b0;
			end
			if (w_take) begin
				wready_r <= 1'b0;
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end else if (do_write) begin
				wready_r <= 1'b1;
				w_held_r <= 1'b0;
			end
		end
	end

	// answer each write, error for unmapped addresses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	// one read at a time, data one cycle after the handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= `RESP_OKAY;
			rd_ctrl_r <= 1'b0;
		end else if (ar_take) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rd_word;
			rresp_r   <= (rsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			rd_ctrl_r <= (rsel == SEL_CTRL);
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	// ----------------------------------------
	// port drive
	// ----------------------------------------
	assign s_axi_awready       = awready_r;
	assign s_axi_wready        = wready_r;
	assign s_axi_bvalid        = bvalid_r;
	assign s_axi_bresp         = bresp_r;
	assign s_axi_arready       = arready_r;
	assign s_axi_rvalid        = rvalid_r;
	assign s_axi_rdata         = rdata_r;
	assign s_axi_rresp         = rresp_r;
	assign msg_fire            = fire_r;
	assign intx_n              = intx_n_r;
	assign extended_msg_irq_on = ctrl_r.en;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_reset_off;
		@(posedge aclk) !aresetn |=> (ctrl_r.en == 1'b0);
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("enable not clear after reset");

	property p_legacy_pin;
		@(posedge aclk) disable iff (!aresetn)
		(legacy_on && (|pend_r)) |=> !intx_n;
	endproperty
	a_legacy_pin: assert property (p_legacy_pin) else $error("legacy pin not asserted");

	property p_no_pin;
		@(posedge aclk) disable iff (!aresetn)
		(ctrl_r.en && !plain_msg_irq_on) |=> intx_n;
	endproperty
	a_no_pin: assert property (p_no_pin) else $error("legacy pin used in message mode");

	property p_no_msg;
		@(posedge aclk) disable iff (!aresetn)
		!ctrl_r.en |=> (msg_fire == '0);
	endproperty
	a_no_msg: assert property (p_no_msg) else $error("message issued while disabled");

	property p_fmask;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_r.fmask |=> (msg_fire == '0);
	endproperty
	a_fmask: assert property (p_fmask) else $error("message under function mask");

	property p_own_mask;
		@(posedge aclk) disable iff (!aresetn)
		(ctrl_r.en && !plain_msg_irq_on && !ctrl_r.fmask && pend_r[0] && !vmask_r[0])
		|=> msg_fire[0];
	endproperty
	a_own_mask: assert property (p_own_mask) else $error("unmasked vector not fired");

	property p_keep_vmask;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && wsel == SEL_CTRL) |=> $stable(vmask_r);
	endproperty
	a_keep_vmask: assert property (p_keep_vmask) else $error("vector masks moved");

	property p_fmask_rw;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_wr |=> (ctrl_r.fmask == $past(wdata_r[`BIT_FMASK]));
	endproperty
	a_fmask_rw: assert property (p_fmask_rw) else $error("function mask not written");

	property p_rsv_zero;
		@(posedge aclk) disable iff (!aresetn)
		(rvalid_r && rd_ctrl_r) |-> (s_axi_rdata[`RSV_HI:`RSV_LO] == 3'h0);
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");

	property p_size;
		@(posedge aclk) disable iff (!aresetn)
		(rvalid_r && rd_ctrl_r) |-> (s_axi_rdata[`SIZE_HI:0] == SIZE_CODE);
	endproperty
	a_size: assert property (p_size) else $error("size field wrong");

endmodule // msix_message_control
`default_nettype wire

// *** verification/sw_model.sv ***
// configuration software model: axi4-lite master on the control register bus
`timescale 1ns/100ps
`default_nettype none
module sw_model (
	// clock
	input  wire logic        aclk,
	// write channels
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	// read channels
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	// idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// one write; only this party writes the control bits
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= 3'h7;
		forever begin
			@(posedge aclk);
			// released lines show a changed value, not the last one
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	// one read: arvalid held until arready, rready until rvalid is seen
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr  <= ~a;
			end
			if (rvalid) begin
				{d, r} = {rdata, rresp};
				rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule // sw_model
`default_nettype wire

// *** verification/msix_message_control_tb_top.sv ***
// self-checking bench of the vector message control block
`timescale 1ns/100ps
`default_nettype none
`include "msix_ctrl_defines.svh"
module msix_message_control_tb_top;
	import msix_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int NV = 4;                   // table entries
	localparam logic [31:0] SZ = 32'(NV - 1); // size field
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [3:0]  s;
		logic [31:0] x;
		logic [1:0]  r;
	} row_t;
	logic aclk, aresetn, awv, awr, wv, wr_, bv, br_, arv, arr, rv, rr_, plain, intx_n, ext;
	logic [7:0]    awa, ara;
	logic [31:0]   wd, rdt, rd_d, rdt2;
	logic          intx_n2;                   // legacy pin of the pinless twin
	logic [3:0]    ws;
	logic [1:0]    bre, rre, br, rr;
	logic [NV-1:0] vec_req, msg_fire;
	int n_tests = 0, bad_count = 0, cycles = 0, nlow = 0, c;
	int nfire [NV] = '{default: 0}; // pulses seen per vector
	// register accesses and one unmapped address: write, read back
	row_t rows [6] = '{
		'{`OFS_CTRL, 32'hFFFF_FFFF, 4'hF, 32'h0000_C000 | SZ, `RESP_OKAY},
		'{`OFS_CTRL, 32'h0000_0000, 4'hF, SZ, `RESP_OKAY},
		'{`OFS_CTRL, 32'h0000_C7FF, 4'h1, SZ, `RESP_OKAY},
		'{`OFS_VMASK, 32'h0000_000F, 4'hF, 32'h0000_000F, `RESP_OKAY},
		'{`OFS_VMASK, 32'h0000_0005, 4'hF, 32'h0000_0005, `RESP_OKAY},
		'{8'h10, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, `RESP_SLVERR}};
	// status reads per enable pair
	logic [32:0] modes [3] = '{{1'b0, 32'h0}, {1'b0, 32'h8000}, {1'b1, 32'h8000}};
	irq_mode_t   mexp [3] = '{MODE_INTX, MODE_MSIX, MODE_MSI};
	// ----------------------------------------
	// instances
	// ----------------------------------------
	msix_message_control #(.NUM_VEC(NV), .INTX_SUPPORTED(1'b1)) u_msix_message_control (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br_),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
		.s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr_), .vec_req(vec_req),
		.plain_msg_irq_on(plain), .msg_fire(msg_fire), .intx_n(intx_n),
		.extended_msg_irq_on(ext));
	sw_model u_sw_model (
		.aclk(aclk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(ws),
		.wvalid(wv), .wready(wr_), .bresp(bre), .bvalid(bv), .bready(br_), .araddr(ara),
		.arvalid(arv), .arready(arr), .rdata(rdt), .rresp(rre), .rvalid(rv), .rready(rr_));
	// twin without a legacy pin, fed the same traffic; it tracks the first one except for the pin and the status mode with both enables clear
	msix_message_control #(.NUM_VEC(NV), .INTX_SUPPORTED(1'b0)) u_msix_message_control_nopin (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(br_),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(), .s_axi_rdata(rdt2),
		.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rr_), .vec_req(vec_req),
		.plain_msg_irq_on(plain), .msg_fire(), .intx_n(intx_n2),
		.extended_msg_irq_on());
	// ----------------------------------------
	// clock, monitors, timeout
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// count fire pulses and legacy pin low cycles
	always @(posedge aclk) begin
		for (int i = 0; i < NV; i++) if (msg_fire[i] === 1'b1) nfire[i]++;
		if (intx_n === 1'b0) nlow++;
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		u_sw_model.wr(a, d, 4'hF, br);
	endtask
	task automatic r(input logic [7:0] a);
		u_sw_model.rd(a, rd_d, rr);
	endtask
	// one-cycle request on the vectors in m
	task automatic pulse(input logic [NV-1:0] m);
		@(posedge aclk);
		vec_req <= m;
		@(posedge aclk);
		vec_req <= '0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{aresetn, vec_req, plain} = '0;
		cyc(2);
		aresetn <= 1'b1;
		cyc(1);
		// reset state
		chk(32'(ext), 0, "enable out");
		chk(32'(intx_n), 1, "legacy pin idle");
		r(`OFS_CTRL);
		chk(rd_d, SZ, "control reset");
		$display("test reset done");
		// register table
		foreach (rows[i]) begin
			u_sw_model.wr(rows[i].a, rows[i].d, rows[i].s, br);
			chk(32'(br), 32'(rows[i].r), "write resp");
			r(rows[i].a);
			chk(rd_d, rows[i].x, "read back");
			chk(32'(rr), 32'(rows[i].r), "read resp");
		end
		$display("test table done");
		// function mask over vector masks
		w(`OFS_VMASK, 32'h5);
		w(`OFS_CTRL, 32'hC000);
		chk(32'(ext), 1, "enable out");
		r(`OFS_VMASK);
		chk(rd_d, 32'h5, "vmask kept");
		c = nfire[1];
		pulse(4'h2);
		cyc(3);
		chk(32'(nfire[1]), 32'(c), "fmask holds");
		w(`OFS_CTRL, 32'h8000);
		cyc(2);
		chk(32'(nfire[1]), 32'(c + 1), "fires on unmask");
		r(`OFS_VMASK);
		chk(rd_d, 32'h5, "vmask kept");
		c = nfire[0];
		pulse(4'h1);
		cyc(3);
		chk(32'(nfire[0]), 32'(c), "own mask holds");
		w(`OFS_VMASK, 32'h0);
		cyc(2);
		chk(32'(nfire[0]), 32'(c + 1), "fires after own unmask");
		$display("test masks done");
		// message timing, no legacy pin in message mode
		c = nlow;
		pulse(4'h8);
		#1 chk(32'(msg_fire), 32'h8, "fire pulse");
		@(posedge aclk);
		#1 chk(32'(msg_fire), 32'h0, "pulse one cycle");
		chk(32'(nlow), 32'(c), "pin quiet");
		$display("test timing done");
		// disabled: legacy pin, no message
		w(`OFS_CTRL, 32'h0);
		c = nfire[2];
		pulse(4'h4);
		cyc(3);
		chk(32'(intx_n), 0, "legacy asserted");
		chk(32'(intx_n2), 1, "no pin fitted");
		chk(32'(nfire[2]), 32'(c), "no message");
		w(`OFS_PEND, 32'h4);
		cyc(2);
		chk(32'(intx_n), 1, "legacy released");
		$display("test legacy done");
		// status mode per enable pair
		foreach (modes[i]) begin
			@(posedge aclk);
			plain <= modes[i][32];
			w(`OFS_CTRL, modes[i][31:0]);
			r(`OFS_STAT);
			chk(rd_d, 32'(mexp[i]), "mode");
			chk(rdt2, (i == 0) ? 32'(MODE_OFF) : 32'(mexp[i]), "mode without pin");
		end
		// plain messages on: hold pending, no pin
		c = nfire[2];
		pulse(4'h4);
		cyc(3);
		chk(32'(nfire[2]), 32'(c), "plain blocks");
		chk(32'(intx_n), 1, "pin quiet");
		plain <= 1'b0;
		cyc(3);
		chk(32'(nfire[2]), 32'(c + 1), "fires after plain off");
		$display("test plain done");
		// reset in mid run
		w(`OFS_CTRL, 32'hC000);
		@(posedge aclk);
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		cyc(1);
		chk(32'(ext), 0, "enable out");
		r(`OFS_CTRL);
		chk(rd_d, SZ, "control reset");
		$display("test rereset done");
		print_verdict();
	end
endmodule // msix_message_control_tb_top
`default_nettype wire
